//--- core/ebtc_top.v
// counter unit of the eight-bit timer counter with one compare channel
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ebtc_regs.vh"

module ebtc_top #(
  parameter W = 8
) (
  input  wire                    mclk,
  input  wire                    srst,
  input  wire [`EBTC_ADDR_W-1:0] addr,
  input  wire [W-1:0]            wr_data,
  input  wire                    wr_en,
  input  wire                    rd_en,
  input  wire                    external_count_pin,
  output reg  [W-1:0]            rd_data_q,
  output reg                     ovf_req_q,
  output reg                     cmp_req_q,
  output reg                     compare_match_q,
  output reg                     compare_output_pin_q,
  output reg                     bottom_q,
  output reg                     max_q,
  output reg                     top_q
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [W-1:0] count_value_q;
  reg [W-1:0] count_value_d;
  reg         dir_down_q;
  reg         dir_down_d;
  reg         block_q;
  reg         block_d;
  reg [2:0]   clock_source_select_q;
  reg [1:0]   wave_gen_mode_q;
  reg [1:0]   timer_flag_q;
  reg [1:0]   timer_flag_d;
  reg [1:0]   timer_mask_q;
  reg [W-1:0] rd_data_d;
  reg         ovf_set;
  reg         cmp_set;
  reg         match;
  reg         reload;
  reg [W-1:0] top_val;
  reg         pin_d;
  reg         bottom_d;
  reg         max_d;
  reg         top_d;
  reg         ovf_req_d;
  reg         cmp_req_d;

  wire         timer_tick;
  wire [W-1:0] compare_value;
  wire [W-1:0] compare_active;
  wire         pwm_mode;
  wire         wr_ctrl;
  wire         wr_count;
  wire         wr_cmp;
  wire         wr_flag;
  wire         wr_mask;
  wire         force_cmp;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign wr_ctrl   = wr_en && (addr == `EBTC_OFF_CTRL);
  assign wr_count  = wr_en && (addr == `EBTC_OFF_COUNT);
  assign wr_cmp    = wr_en && (addr == `EBTC_OFF_CMP);
  assign wr_flag   = wr_en && (addr == `EBTC_OFF_FLAG);
  assign wr_mask   = wr_en && (addr == `EBTC_OFF_MASK);
  assign pwm_mode  = wave_gen_mode_q[0]; // modes one and three buffer the compare value
  // the force strobe only acts while a non-pwm mode is in use
  assign force_cmp = wr_ctrl && wr_data[`EBTC_FORCE] && !pwm_mode;

  // ----------------------------------------
  // tick source
  // ----------------------------------------
  ebtc_tick_sel #(
    .PRE_W (`EBTC_PRE_W)
  ) u_tick (
    .mclk                (mclk),
    .srst                (srst),
    .clock_source_select (clock_source_select_q),
    .external_count_pin  (external_count_pin),
    .timer_tick          (timer_tick)
  );

  // ----------------------------------------
  // compare value with double buffer
  // ----------------------------------------
  ebtc_cmp_buf #(
    .W (W)
  ) u_cmp (
    .mclk     (mclk),
    .srst     (srst),
    .wr       (wr_cmp),
    .wdata    (wr_data),
    .buffered (pwm_mode),
    .reload   (reload),
    .buf_val  (compare_value),
    .act_val  (compare_active)
  );

  // ----------------------------------------
  // top value by mode
  // ----------------------------------------
  always @* begin
    if (wave_gen_mode_q == `EBTC_WGM_CTC) begin
      top_val = compare_active;
    end else begin
      top_val = `EBTC_MAX;
    end
  end

  // ----------------------------------------
  // counter sequence, flags and blocking
  // ----------------------------------------
  always @* begin
    count_value_d = count_value_q;
    dir_down_d    = dir_down_q;
    ovf_set       = 1'b0;
    cmp_set       = 1'b0;
    reload        = 1'b0;
    block_d       = block_q;
    // comparator runs every cycle, gated only by a pending block
    match = (count_value_q == compare_active) && !block_q;
    if (timer_tick) begin
      block_d = 1'b0;
      cmp_set = match;
      case (wave_gen_mode_q)
        `EBTC_WGM_NORMAL: begin
          count_value_d = count_value_q + `EBTC_ONE;
          ovf_set       = (count_value_q == `EBTC_MAX);
        end
        `EBTC_WGM_CTC: begin
          if (match) begin
            count_value_d = `EBTC_BOTTOM;
          end else begin
            count_value_d = count_value_q + `EBTC_ONE;
          end
          ovf_set = (count_value_q == `EBTC_MAX);
        end
        `EBTC_WGM_FPWM: begin
          count_value_d = count_value_q + `EBTC_ONE;
          ovf_set       = (count_value_q == `EBTC_MAX);
          reload        = (count_value_q == `EBTC_MAX);
        end
        `EBTC_WGM_PCPWM: begin
          if (!dir_down_q) begin
            if (count_value_q == `EBTC_MAX) begin
              dir_down_d    = 1'b1;
              count_value_d = count_value_q - `EBTC_ONE;
              reload        = 1'b1;
            end else begin
              count_value_d = count_value_q + `EBTC_ONE;
            end
          end else begin
            if (count_value_q == `EBTC_BOTTOM) begin
              dir_down_d    = 1'b0;
              count_value_d = count_value_q + `EBTC_ONE;
              ovf_set       = 1'b1;
            end else begin
              count_value_d = count_value_q - `EBTC_ONE;
            end
          end
        end
        default: begin
          count_value_d = count_value_q;
        end
      endcase
    end
    // software write beats any clear or count of the same cycle
    if (wr_count) begin
      count_value_d = wr_data;
      dir_down_d    = dir_down_q;
      ovf_set       = 1'b0;
      block_d       = 1'b1;
    end
  end

  // ----------------------------------------
  // flags: hardware set wins over write-one clear
  // ----------------------------------------
  always @* begin
    timer_flag_d = timer_flag_q;
    if (wr_flag) begin
      timer_flag_d = timer_flag_q & ~wr_data[`EBTC_FLAG_CMP:`EBTC_FLAG_OVF];
    end
    if (ovf_set) begin
      timer_flag_d[`EBTC_FLAG_OVF] = 1'b1;
    end
    if (cmp_set) begin
      timer_flag_d[`EBTC_FLAG_CMP] = 1'b1;
    end
  end

  // ----------------------------------------
  // waveform generator: next level of the compare output
  // ----------------------------------------
  always @* begin
    pin_d = compare_output_pin_q;
    // a forced match moves the output only; it sets no flag and clears nothing
    if (cmp_set || force_cmp) begin
      pin_d = ~compare_output_pin_q;
    end
  end

  // ----------------------------------------
  // next status levels and masked requests
  // ----------------------------------------
  always @* begin
    // decoding the next value keeps the status outputs in step with the counter
    bottom_d  = (count_value_d == `EBTC_BOTTOM);
    max_d     = (count_value_d == `EBTC_MAX);
    top_d     = (count_value_d == top_val);
    ovf_req_d = timer_flag_d[`EBTC_FLAG_OVF] & timer_mask_q[`EBTC_FLAG_OVF];
    cmp_req_d = timer_flag_d[`EBTC_FLAG_CMP] & timer_mask_q[`EBTC_FLAG_CMP];
  end

  // ----------------------------------------
  // read mux, unmapped reads give zero
  // ----------------------------------------
  always @* begin
    rd_data_d = `EBTC_RST_BYTE;
    if (rd_en) begin
      case (addr)
        `EBTC_OFF_CTRL: begin
          rd_data_d[`EBTC_CS_MSB:`EBTC_CS_LSB] = clock_source_select_q;
          rd_data_d[`EBTC_WGM_HI:`EBTC_WGM_LO] = wave_gen_mode_q;
        end
        `EBTC_OFF_COUNT: begin
          rd_data_d = count_value_q;
        end
        `EBTC_OFF_CMP: begin
          rd_data_d = compare_value;
        end
        `EBTC_OFF_FLAG: begin
          rd_data_d[`EBTC_FLAG_CMP:`EBTC_FLAG_OVF] = timer_flag_q;
        end
        `EBTC_OFF_MASK: begin
          rd_data_d[`EBTC_FLAG_CMP:`EBTC_FLAG_OVF] = timer_mask_q;
        end
        default: begin
          rd_data_d = `EBTC_RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      count_value_q         <= `EBTC_RST_BYTE;
      dir_down_q            <= 1'b0;
      block_q               <= 1'b0;
      clock_source_select_q <= `EBTC_RST_CS;
      wave_gen_mode_q       <= `EBTC_RST_WGM;
      timer_flag_q          <= `EBTC_RST_FLAGS;
      timer_mask_q          <= `EBTC_RST_FLAGS;
      rd_data_q             <= `EBTC_RST_BYTE;
    end else begin
      count_value_q <= count_value_d;
      dir_down_q    <= dir_down_d;
      block_q       <= block_d;
      timer_flag_q  <= timer_flag_d;
      rd_data_q     <= rd_data_d;
      if (wr_ctrl) begin
        clock_source_select_q <= wr_data[`EBTC_CS_MSB:`EBTC_CS_LSB];
        wave_gen_mode_q       <= wr_data[`EBTC_WGM_HI:`EBTC_WGM_LO];
        if (!wr_data[`EBTC_WGM_LO]) begin
          dir_down_q <= 1'b0; // non-pwm modes only count up
        end
      end
      if (wr_mask) begin
        timer_mask_q <= wr_data[`EBTC_FLAG_CMP:`EBTC_FLAG_OVF];
      end
    end
  end

  // ----------------------------------------
  // status outputs and masked requests
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      ovf_req_q            <= 1'b0;
      cmp_req_q            <= 1'b0;
      compare_match_q      <= 1'b0;
      compare_output_pin_q <= 1'b0;
      bottom_q             <= 1'b1;
      max_q                <= 1'b0;
      top_q                <= 1'b0;
    end else begin
      ovf_req_q            <= ovf_req_d;
      cmp_req_q            <= cmp_req_d;
      compare_match_q      <= cmp_set;
      compare_output_pin_q <= pin_d;
      bottom_q             <= bottom_d;
      max_q                <= max_d;
      top_q                <= top_d;
    end
  end

endmodule

//--- core/ebtc_regs.vh
// register map, field positions and constants of the eight-bit timer counter unit
//
// Notes on behaviour
// - counter and compare value are 8-bit registers, readable and writable by software
// - every request shows in the flag register; each is masked separately
// - tick comes from prescaled system clock or from the external count pin
// - clock source select zero gives no tick; counter stays stopped
// - three-bit clock source select picks tick source and active pin edge
// - compare value and counter are compared every cycle; match drives waveform output
// - compare match sets the compare flag, which may raise a request
// - bottom is signalled when the counter value is all zeros
// - max is signalled when the counter value is all ones
// - top is max, or the compare value, depending on mode
// - counter moves by one per tick, up or down by a direction control
// - each tick clears, increments or decrements the counter by mode
// - software may read and write the counter at any time
// - a software write to the counter beats a same-cycle clear or count
// - two wave generation mode bits in the control register set the sequence
// - overflow flag is set at a mode dependent point and may raise a request
// - compare flag sets in the tick after counter equals compare value
// - mode zero counts up, wraps to zero, overflow flag set as counter becomes zero
// - mode two clears the counter on compare match, compare value is top
// - a counter write blocks compare match in the next tick, even when stopped
`ifndef EBTC_REGS_VH
`define EBTC_REGS_VH

// register offsets
`define EBTC_ADDR_W     3
`define EBTC_OFF_CTRL   3'h0
`define EBTC_OFF_COUNT  3'h1
`define EBTC_OFF_CMP    3'h2
`define EBTC_OFF_FLAG   3'h3
`define EBTC_OFF_MASK   3'h4

// control register fields
`define EBTC_CS_LSB     0
`define EBTC_CS_MSB     2
`define EBTC_WGM_LO     3
`define EBTC_WGM_HI     4
`define EBTC_FORCE      5

// flag and mask register fields
`define EBTC_FLAG_OVF   0
`define EBTC_FLAG_CMP   1

// values and reset values
`define EBTC_BOTTOM     8'h00
`define EBTC_MAX        8'hff
`define EBTC_ONE        8'h01
`define EBTC_RST_BYTE   8'h00
`define EBTC_RST_CS     3'h0
`define EBTC_RST_WGM    2'h0
`define EBTC_RST_FLAGS  2'h0

// wave generation modes
`define EBTC_WGM_NORMAL 2'h0
`define EBTC_WGM_PCPWM  2'h1
`define EBTC_WGM_CTC    2'h2
`define EBTC_WGM_FPWM   2'h3

// clock source select codes
`define EBTC_CS_OFF     3'h0
`define EBTC_CS_DIV1    3'h1
`define EBTC_CS_DIV8    3'h2
`define EBTC_CS_DIV64   3'h3
`define EBTC_CS_DIV256  3'h4
`define EBTC_CS_DIV1024 3'h5
`define EBTC_CS_EXTFALL 3'h6
`define EBTC_CS_EXTRISE 3'h7

// prescaler width and tap widths
`define EBTC_PRE_W      10
`define EBTC_TAP8       3
`define EBTC_TAP64      6
`define EBTC_TAP256     8
`define EBTC_TAP1024    10

`endif

//--- core/ebtc_tick_sel.v
// timer tick selection: prescaler taps and external count pin edge detect
`timescale 1ns/10ps
`include "ebtc_regs.vh"

module ebtc_tick_sel #(
  parameter PRE_W = `EBTC_PRE_W
) (
  input  wire       mclk,
  input  wire       srst,
  input  wire [2:0] clock_source_select,
  input  wire       external_count_pin,
  output wire       timer_tick
);

  reg [PRE_W-1:0] pre_q;
  reg             pin_q;
  reg             tick_q;
  reg             tick_d;

  assign timer_tick = tick_q;

  // ----------------------------------------
  // free running prescaler and pin history
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      pre_q  <= {PRE_W{1'b0}};
      pin_q  <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      pin_q  <= external_count_pin;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // source and edge choice
  // ----------------------------------------
  always @* begin
    case (clock_source_select)
      `EBTC_CS_OFF:     tick_d = 1'b0;
      `EBTC_CS_DIV1:    tick_d = 1'b1;
      `EBTC_CS_DIV8:    tick_d = &pre_q[`EBTC_TAP8-1:0];
      `EBTC_CS_DIV64:   tick_d = &pre_q[`EBTC_TAP64-1:0];
      `EBTC_CS_DIV256:  tick_d = &pre_q[`EBTC_TAP256-1:0];
      `EBTC_CS_DIV1024: tick_d = &pre_q[`EBTC_TAP1024-1:0];
      `EBTC_CS_EXTFALL: tick_d = pin_q & ~external_count_pin;
      `EBTC_CS_EXTRISE: tick_d = ~pin_q & external_count_pin;
      default:          tick_d = 1'b0;
    endcase
  end

endmodule

//--- core/ebtc_cmp_buf.v
// double-buffered compare value: software buffer and active compare register
`timescale 1ns/10ps
`include "ebtc_regs.vh"

module ebtc_cmp_buf #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire         wr,
  input  wire [W-1:0] wdata,
  input  wire         buffered,
  input  wire         reload,
  output wire [W-1:0] buf_val,
  output wire [W-1:0] act_val
);

  reg [W-1:0] buf_q;
  reg [W-1:0] act_q;

  assign buf_val = buf_q;
  assign act_val = act_q;

  // ----------------------------------------
  // buffer takes writes; active copy loads directly or at reload
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      buf_q <= {W{1'b0}};
      act_q <= {W{1'b0}};
    end else begin
      if (wr) begin
        buf_q <= wdata;
      end
      if (wr && !buffered) begin
        act_q <= wdata; // direct access outside pwm modes
      end else if (buffered && reload) begin
        act_q <= buf_q;
      end
    end
  end

endmodule

//--- bench/ebtc_assertions.sv
// port level checks of the timer counter unit
`timescale 1ns/10ps
module ebtc_assertions #(
  parameter W = 8
) (
  input wire         mclk,
  input wire         srst,
  input wire [2:0]   addr,
  input wire [W-1:0] wr_data,
  input wire         wr_en,
  input wire         rd_en,
  input wire         external_count_pin,
  input wire [W-1:0] rd_data_q,
  input wire         ovf_req_q,
  input wire         cmp_req_q,
  input wire         compare_match_q,
  input wire         compare_output_pin_q,
  input wire         bottom_q,
  input wire         max_q,
  input wire         top_q
);
  reg [2:0] cs_q;
  reg       mk_q;
  reg [2:0] idle_q;
  // ----------------------------------------
  // helper: source select, mask, stopped run
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      cs_q   <= 3'h0;
      mk_q   <= 1'b0;
      idle_q <= 3'h0;
    end else begin
      if (wr_en && addr == 3'h0)
        cs_q <= wr_data[2:0];
      if (wr_en && addr == 3'h4)
        mk_q <= wr_data[0];
      if (cs_q != 3'h0 || (wr_en && addr == 3'h1) || (wr_en && addr == 3'h0 && wr_data[2:0] != 3'h0))
        idle_q <= 3'h0;
      else if (idle_q != 3'h7)
        idle_q <= idle_q + 3'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data_q == 0)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property ($past(rd_en) && $past(addr) > 3'h4 |-> rd_data_q == 0)
    else $error("unmapped read not zero");
  a_write_wins: assert property (wr_en && addr == 3'h1 ##1 rd_en && addr == 3'h1 |=> rd_data_q == $past(wr_data, 2))
    else $error("count write lost");
  a_cmp_readback: assert property (wr_en && addr == 3'h2 ##1 rd_en && addr == 3'h2 |=> rd_data_q == $past(wr_data, 2))
    else $error("compare readback wrong");
  a_zero_bottom: assert property (wr_en && addr == 3'h1 && wr_data == 0 && cs_q == 0 && $past(cs_q) == 0 |-> ##2 bottom_q)
    else $error("bottom missing");
  a_ones_max: assert property (wr_en && addr == 3'h1 && wr_data == 8'hff && cs_q == 0 && $past(cs_q) == 0 |-> ##2 max_q)
    else $error("max missing");
  a_masked_quiet: assert property (!mk_q && !$past(mk_q) |-> !ovf_req_q)
    else $error("masked overflow request");
  a_stop_holds: assert property (idle_q == 3'h7 |-> $stable(bottom_q) && $stable(max_q) && !compare_match_q)
    else $error("stopped counter moved");
  c_match: cover property (compare_match_q);
  c_ovf: cover property (ovf_req_q);
  c_top: cover property (top_q && !max_q);
endmodule
bind ebtc_top ebtc_assertions #(.W(W)) u_ebtc_assertions (.mclk(mclk), .srst(srst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .external_count_pin(external_count_pin),
  .rd_data_q(rd_data_q), .ovf_req_q(ovf_req_q), .cmp_req_q(cmp_req_q), .compare_match_q(compare_match_q),
  .compare_output_pin_q(compare_output_pin_q), .bottom_q(bottom_q), .max_q(max_q), .top_q(top_q));

//--- bench/ebtc_top_tb_top.sv
// self-checking bench of the timer counter unit
`timescale 1ns/10ps
`include "ebtc_regs.vh"
module ebtc_top_tb_top;
  localparam [2:0] CTL = `EBTC_OFF_CTRL;
  localparam [2:0] CNT = `EBTC_OFF_COUNT;
  localparam [2:0] CMP = `EBTC_OFF_CMP;
  localparam [2:0] FLG = `EBTC_OFF_FLAG;
  localparam [2:0] MSK = `EBTC_OFF_MASK;
  reg        mclk;
  reg        srst;
  reg  [2:0] addr;
  reg  [7:0] wr_data;
  reg        wr_en;
  reg        rd_en;
  reg        external_count_pin;
  wire [7:0] rd_data_q;
  wire       ovf_req_q;
  wire       cmp_req_q;
  wire       compare_match_q;
  wire       compare_output_pin_q;
  wire       bottom_q;
  wire       max_q;
  wire       top_q;
  integer    error_cnt;
  integer    comparisons;
  integer    cyc;
  integer    pulses;
  integer    p0;
  integer    dv;
  integer    i;
  reg  [7:0] q;

  ebtc_top u_ebtc_top (.mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .external_count_pin(external_count_pin), .rd_data_q(rd_data_q), .ovf_req_q(ovf_req_q),
    .cmp_req_q(cmp_req_q), .compare_match_q(compare_match_q), .compare_output_pin_q(compare_output_pin_q),
    .bottom_q(bottom_q), .max_q(max_q), .top_q(top_q));

  // clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // match pulse count and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (compare_match_q === 1'b1)
      pulses <= pulses + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end

  task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_en   <= 1'b0;
    end
  endtask

  task rd(input [2:0] a);
    begin
      @(posedge mclk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 q = rd_data_q;
    end
  endtask

  // write then read the same place back to back
  task wrrd(input [2:0] a, input [7:0] d);
    begin
      wr(a, d);
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 q = rd_data_q;
    end
  endtask

  task t_reset;
    begin
      #1 chk("bottom", 8'h01, {7'h0, bottom_q});
      for (i = 0; i < 5; i = i + 1) begin
        rd(i[2:0]);
        chk("reset reg", 8'h00, q);
      end
      wr(3'h5, 8'hff);
      rd(3'h5);
      chk("unmapped", 8'h00, q);
      $display("t_reset done");
    end
  endtask

  task t_stopped;
    begin
      wrrd(CNT, 8'ha5);
      chk("count wr", 8'ha5, q);
      repeat (20) @(posedge mclk);
      rd(CNT);
      chk("count hold", 8'ha5, q);
      wrrd(CMP, 8'h5a);
      chk("cmp wr", 8'h5a, q);
      wr(CNT, 8'hff);
      repeat (2) @(posedge mclk);
      #1 chk("max", 8'h01, {7'h0, max_q});
      chk("top max", 8'h01, {7'h0, top_q});
      wr(CNT, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk("bottom", 8'h01, {7'h0, bottom_q});
      $display("t_stopped done");
    end
  endtask

  task t_normal;
    begin
      wr(CNT, 8'hfc);
      wr(CTL, 8'h01);
      repeat (10) @(posedge mclk);
      wrrd(CNT, 8'h40);
      chk("wr prio", 8'h40, q);
      wr(CTL, 8'h00);
      rd(CNT);
      chk("count up", 8'h01, {7'h0, q > 8'h40 && q < 8'h50});
      rd(FLG);
      chk("ovf flag", 8'h01, q);
      chk("ovf mask", 8'h00, {7'h0, ovf_req_q});
      wr(MSK, 8'h01);
      repeat (2) @(posedge mclk);
      #1 chk("ovf req", 8'h01, {7'h0, ovf_req_q});
      wr(FLG, 8'h01);
      rd(FLG);
      chk("ovf clear", 8'h00, q);
      wr(MSK, 8'h00);
      $display("t_normal done");
    end
  endtask

  task t_ctc;
    begin
      wr(CTL, 8'h10);
      wr(CNT, 8'h00);
      wr(CMP, 8'h03);
      wr(MSK, 8'h02);
      wr(CTL, 8'h11);
      for (i = 0; i < 6; i = i + 1) begin
        rd(CNT);
        chk("ctc top", 8'h01, {7'h0, q < 8'h04});
      end
      p0 = pulses;
      repeat (40) @(posedge mclk);
      chk("match rate", 8'h01, {7'h0, pulses - p0 >= 9 && pulses - p0 <= 11});
      wr(CTL, 8'h10);
      rd(FLG);
      chk("cmp flag", 8'h02, q);
      chk("cmp req", 8'h01, {7'h0, cmp_req_q});
      wr(CNT, 8'h03);
      repeat (2) @(posedge mclk);
      #1 chk("cmp top", 8'h01, {7'h0, top_q && !max_q});
      $display("t_ctc done");
    end
  endtask

  task t_block;
    begin
      wr(CTL, 8'h00);
      wr(CMP, 8'h10);
      for (i = 0; i < 2; i = i + 1) begin
        wr(CNT, 8'h10 - i[7:0]);
        wr(FLG, 8'h03);
        p0 = pulses;
        dv = compare_output_pin_q;
        wr(CTL, 8'h01);
        repeat (3) @(posedge mclk);
        wr(CTL, 8'h00);
        repeat (3) @(posedge mclk);
        rd(FLG);
        chk("blocked", {6'h0, i[0], 1'b0}, q & 8'h02);
        chk("match cnt", i[7:0], pulses - p0);
        chk("match pin", {7'h0, dv[0] ^ i[0]}, {7'h0, compare_output_pin_q});
      end
      $display("t_block done");
    end
  endtask

  task t_src;
    begin
      for (i = 6; i < 8; i = i + 1) begin
        wr(CNT, 8'h00);
        wr(CTL, i[7:0]);
        repeat (5) begin
          @(posedge mclk);
          external_count_pin <= 1'b1;
          repeat (3) @(posedge mclk);
          external_count_pin <= 1'b0;
          repeat (3) @(posedge mclk);
        end
        wr(CTL, 8'h00);
        rd(CNT);
        chk("pin edges", 8'h05, q);
      end
      for (i = 2; i < 6; i = i + 1) begin
        dv = (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
        wr(CNT, 8'h00);
        wr(CTL, i[7:0]);
        repeat (1500) @(posedge mclk);
        wr(CTL, 8'h00);
        rd(CNT);
        chk("prescale", 8'h01, {7'h0, q + 1 >= 1500 / dv && q <= 1500 / dv + 2});
      end
      $display("t_src done");
    end
  endtask

  task t_modes;
    begin
      for (i = 1; i < 4; i = i + 2) begin
        wr(CNT, 8'h00);
        wr(CTL, (i[7:0] << 3) | 8'h01);
        repeat (300) @(posedge mclk);
        wr(CTL, i[7:0] << 3);
        rd(CNT);
        chk("mode seq", {7'h0, i == 1}, {7'h0, q > 8'h80});
      end
      $display("t_modes done");
    end
  endtask

  // buffered compare value: no direct load, reload at the max tick
  task t_buffer;
    begin
      wr(CTL, 8'h18);
      wr(CMP, 8'h30);
      wr(FLG, 8'h03);
      for (i = 0; i < 3; i = i + 1) begin
        if (i < 2)
          wr(CNT, (i == 0) ? 8'h28 : 8'hfe);
        wr(CTL, 8'h19);
        repeat (30) @(posedge mclk);
        wr(CTL, 8'h18);
        rd(FLG);
        chk("buffered", {6'h0, i == 2, 1'b0}, q & 8'h02);
      end
      $display("t_buffer done");
    end
  endtask

  // forced match in a non-pwm mode, an ignored force in a pwm mode, then a reset with the compare output high
  task t_force;
    begin
      wr(CTL, 8'h00);
      wr(FLG, 8'h03);
      #1 dv = compare_output_pin_q;
      wr(CTL, 8'h20);
      repeat (2) @(posedge mclk);
      #1 chk("force pin", {7'h0, ~dv[0]}, {7'h0, compare_output_pin_q});
      rd(FLG);
      chk("force flag", 8'h00, q & 8'h02);
      wr(CTL, 8'h08);
      wr(CTL, 8'h28);
      repeat (2) @(posedge mclk);
      #1 chk("pwm force", {7'h0, ~dv[0]}, {7'h0, compare_output_pin_q});
      if (compare_output_pin_q !== 1'b1) begin
        wr(CTL, 8'h00);
        wr(CTL, 8'h20);
      end
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1 chk("rst pin", 8'h00, {7'h0, compare_output_pin_q});
      chk("rst top", 8'h00, {7'h0, top_q});
      rd(CTL);
      chk("rst ctrl", 8'h00, q);
      $display("t_force done");
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // reset then run every scenario
  initial begin
    srst = 1'b1;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    external_count_pin = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    pulses = 0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_stopped;
    t_normal;
    t_ctc;
    t_block;
    t_src;
    t_modes;
    t_buffer;
    t_force;
    test_done;
  end
endmodule
